// ==== src/trim_cfg_pkg.sv ====
// constants for the serially loaded converter trim and capture configuration registers
// Behaviour
// - 32-bit frame: header, address, data, MSB first
// - settings apply only in extended control mode
// - address 2h: offset magnitude bits 15:8, reset 0
// - offset bit 7 selects sign, reset positive
// - address 3h: 9-bit gain in bits 15:7
// - gain resets to binary midscale 100000000
// - gain change applies without recalibration
// - address Dh: 9-bit fine delay, reset 0
// - Eh bit 15 enables phase adjust, reset 0
// - Eh bits 14:11 coarse delay, reset 0
// - Eh bit 10 low-frequency clock, reset 0
// - Fh bits 15:14 depth select, bit15 resets 1
package trim_cfg_pkg;
  // frame layout
  localparam int unsigned FRAME_BITS  = 32;
  localparam int unsigned HDR_BITS    = 12;
  localparam logic [11:0] HDR_PATTERN = 12'h001;
  // register addresses
  localparam logic [3:0] ADDR_OFFSET = 4'h2;
  localparam logic [3:0] ADDR_GAIN   = 4'h3;
  localparam logic [3:0] ADDR_FINE   = 4'hd;
  localparam logic [3:0] ADDR_COARSE = 4'he;
  localparam logic [3:0] ADDR_STORE  = 4'hf;
  // field positions
  localparam int unsigned OFS_MAG_LSB   = 8;
  localparam int unsigned OFS_SIGN_BIT  = 7;
  localparam int unsigned NINE_LSB      = 7;
  localparam int unsigned PHASE_ON_BIT  = 15;
  localparam int unsigned COARSE_LSB    = 11;
  localparam int unsigned SLOW_CLK_BIT  = 10;
  localparam int unsigned DEPTH_LSB     = 14;
  localparam int unsigned HALT_BIT      = 13;
  localparam int unsigned PATTERN_BIT   = 11;
  // reset values
  localparam logic [7:0] OFS_MAG_RST  = 8'h00;
  localparam logic       OFS_SIGN_RST = 1'b0;
  localparam logic [8:0] GAIN_RST     = 9'h100;
  localparam logic [8:0] FINE_RST     = 9'h000;
  localparam logic       PHASE_ON_RST = 1'b0;
  localparam logic [3:0] COARSE_RST   = 4'h0;
  localparam logic       SLOW_CLK_RST = 1'b0;
  localparam logic [1:0] DEPTH_RST    = 2'h2;
  localparam logic       HALT_RST     = 1'b1;
  localparam logic       PATTERN_RST  = 1'b0;
endpackage : trim_cfg_pkg

// ==== src/trim_cfg_regs.sv ====
// serial loader and write-only trim/capture configuration registers
`timescale 1ns/100ps
module trim_cfg_regs (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  // serial port pins (asynchronous to clk_i)
  input  wire logic       serial_clk_i,
  input  wire logic       serial_in_line_i,
  input  wire logic       serial_select_n_i,
  // mode pin: high selects extended control
  input  wire logic       ext_mode_i,
  // applied settings
  output logic [7:0]      offset_mag_o,
  output logic            offset_neg_o,
  output logic [8:0]      gain_trim_o,
  output logic [8:0]      fine_delay_o,
  output logic            phase_shift_on_o,
  output logic [3:0]      coarse_delay_field_o,
  output logic            slow_sample_clock_bit_o,
  output logic [1:0]      store_depth_select_o,
  output logic            halt_when_full_o,
  output logic            pattern_output_on_o,
  // write strobe: one cycle after any good-header frame, reserved addresses included
  output logic            write_done_o
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers; first stage feeds only the second
  logic [2:0] sync1_q;                  // first stage
  logic [2:0] sync2_q;                  // second stage
  logic       sclk_prev_q;              // for edge detect
  logic       mode_q;                   // synchronised mode level
  logic       ext_mode_meta_q;          // mode pin first stage
  logic       ext_mode_sync_q;          // mode pin second stage

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sync1_q     <= 3'h1;
      sync2_q     <= 3'h1;
      sclk_prev_q <= 1'b0;
    end
    else
    begin
      sync1_q     <= {serial_clk_i, serial_in_line_i, serial_select_n_i};
      sync2_q     <= sync1_q;
      sclk_prev_q <= sync2_q[2];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      mode_q <= 1'b0;
    else
      mode_q <= ext_mode_sync_q;
  end

  // mode pin synchroniser; mode_q above is a third stage that feeds the outputs
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ext_mode_meta_q <= 1'b0;
      ext_mode_sync_q <= 1'b0;
    end
    else
    begin
      ext_mode_meta_q <= ext_mode_i;
      ext_mode_sync_q <= ext_mode_meta_q;
    end
  end

  logic sclk_rise;                      // rising edge of serial clock, sampled
  logic sel_n;                          // synchronised select, active low
  assign sclk_rise = sync2_q[2] & ~sclk_prev_q;
  assign sel_n     = sync2_q[0];

  ////////////////////////////////////////////////////////////////////////////
  // frame shifter: back-to-back frames allowed without releasing select
  logic [30:0] shift_q;                 // first 31 bits of the frame
  logic [4:0]  bit_cnt_q;               // bits taken in the current frame
  logic [31:0] frame;                   // complete frame on the last bit
  logic        frame_end;               // 32nd bit taken this cycle

  assign frame     = {shift_q, sync2_q[1]};
  assign frame_end = sclk_rise & ~sel_n & (bit_cnt_q == 5'h1f);

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      shift_q   <= '0;
      bit_cnt_q <= 5'h00;
    end
    else if (sel_n)
      bit_cnt_q <= 5'h00;               // select high aborts a partial frame
    else if (sclk_rise)
    begin
      shift_q   <= {shift_q[29:0], sync2_q[1]};
      bit_cnt_q <= bit_cnt_q + 5'h01;   // wraps to 0: next frame starts at bit 33
    end
  end

  logic        hdr_ok;                  // header is eleven zeros then a one
  logic [3:0]  waddr;                   // register address
  logic [15:0] wdata;                   // register value
  logic        wr_en;                   // accepted write
  assign hdr_ok = frame[31:20] == trim_cfg_pkg::HDR_PATTERN;
  assign waddr  = frame[19:16];
  assign wdata  = frame[15:0];
  // a malformed header is dropped silently; there is no readback to report it
  assign wr_en  = frame_end & hdr_ok;

  ////////////////////////////////////////////////////////////////////////////
  // stored registers; low filler bits are ignored whatever the host sends
  logic [7:0] ofs_mag_q;
  logic       ofs_sign_q;
  logic [8:0] gain_q;
  logic [8:0] fine_q;
  logic       phase_on_q;
  logic [3:0] coarse_q;
  logic       slow_clk_q;
  logic [1:0] depth_q;
  logic       halt_q;
  logic       pattern_q;
  logic       write_done_q;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ofs_mag_q  <= trim_cfg_pkg::OFS_MAG_RST;
      ofs_sign_q <= trim_cfg_pkg::OFS_SIGN_RST;
      gain_q     <= trim_cfg_pkg::GAIN_RST;
      fine_q     <= trim_cfg_pkg::FINE_RST;
      phase_on_q <= trim_cfg_pkg::PHASE_ON_RST;
      coarse_q   <= trim_cfg_pkg::COARSE_RST;
      slow_clk_q <= trim_cfg_pkg::SLOW_CLK_RST;
      depth_q    <= trim_cfg_pkg::DEPTH_RST;
      halt_q     <= trim_cfg_pkg::HALT_RST;
      pattern_q  <= trim_cfg_pkg::PATTERN_RST;
    end
    else if (wr_en)
    begin
      case (waddr)
        trim_cfg_pkg::ADDR_OFFSET:
        begin
          ofs_mag_q  <= wdata[trim_cfg_pkg::OFS_MAG_LSB +: 8];
          ofs_sign_q <= wdata[trim_cfg_pkg::OFS_SIGN_BIT];
        end
        trim_cfg_pkg::ADDR_GAIN:
          gain_q <= wdata[trim_cfg_pkg::NINE_LSB +: 9];
        trim_cfg_pkg::ADDR_FINE:
          fine_q <= wdata[trim_cfg_pkg::NINE_LSB +: 9];
        trim_cfg_pkg::ADDR_COARSE:
        begin
          phase_on_q <= wdata[trim_cfg_pkg::PHASE_ON_BIT];
          coarse_q   <= wdata[trim_cfg_pkg::COARSE_LSB +: 4];
          slow_clk_q <= wdata[trim_cfg_pkg::SLOW_CLK_BIT];
        end
        trim_cfg_pkg::ADDR_STORE:
        begin
          depth_q   <= wdata[trim_cfg_pkg::DEPTH_LSB +: 2];
          halt_q    <= wdata[trim_cfg_pkg::HALT_BIT];
          pattern_q <= wdata[trim_cfg_pkg::PATTERN_BIT];
        end
        default:
          ;                              // configuration and reserved: not held here
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // applied outputs: defaults in normal mode, stored values in extended mode
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      offset_mag_o            <= trim_cfg_pkg::OFS_MAG_RST;
      offset_neg_o            <= trim_cfg_pkg::OFS_SIGN_RST;
      gain_trim_o             <= trim_cfg_pkg::GAIN_RST;
      fine_delay_o            <= trim_cfg_pkg::FINE_RST;
      phase_shift_on_o        <= trim_cfg_pkg::PHASE_ON_RST;
      coarse_delay_field_o    <= trim_cfg_pkg::COARSE_RST;
      slow_sample_clock_bit_o <= trim_cfg_pkg::SLOW_CLK_RST;
      store_depth_select_o    <= trim_cfg_pkg::DEPTH_RST;
      halt_when_full_o        <= trim_cfg_pkg::HALT_RST;
      pattern_output_on_o     <= trim_cfg_pkg::PATTERN_RST;
    end
    else if (mode_q)
    begin
      // gain is forwarded straight away, no calibration request is raised
      offset_mag_o            <= ofs_mag_q;
      offset_neg_o            <= ofs_sign_q;
      gain_trim_o             <= gain_q;
      fine_delay_o            <= fine_q;
      phase_shift_on_o        <= phase_on_q;
      coarse_delay_field_o    <= coarse_q;
      slow_sample_clock_bit_o <= slow_clk_q;
      store_depth_select_o    <= depth_q;
      halt_when_full_o        <= halt_q;
      pattern_output_on_o     <= pattern_q;
    end
    else
    begin
      // normal mode: contents kept but ignored
      offset_mag_o            <= trim_cfg_pkg::OFS_MAG_RST;
      offset_neg_o            <= trim_cfg_pkg::OFS_SIGN_RST;
      gain_trim_o             <= trim_cfg_pkg::GAIN_RST;
      fine_delay_o            <= trim_cfg_pkg::FINE_RST;
      phase_shift_on_o        <= trim_cfg_pkg::PHASE_ON_RST;
      coarse_delay_field_o    <= trim_cfg_pkg::COARSE_RST;
      slow_sample_clock_bit_o <= trim_cfg_pkg::SLOW_CLK_RST;
      store_depth_select_o    <= trim_cfg_pkg::DEPTH_RST;
      halt_when_full_o        <= trim_cfg_pkg::HALT_RST;
      pattern_output_on_o     <= trim_cfg_pkg::PATTERN_RST;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      write_done_q <= 1'b0;
    else
      write_done_q <= wr_en;
  end
  assign write_done_o = write_done_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  // mode seen high on two samples in a row: outputs then track the stored copies
  sequence s_ext_held;
    mode_q ##1 mode_q;
  endsequence
  // write strobe high for exactly one cycle
  sequence s_done_once;
    write_done_o ##1 !write_done_o;
  endsequence

  a_gain_load: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr_en && waddr == trim_cfg_pkg::ADDR_GAIN |=> gain_q == $past(wdata[15:7]))
    else $error("gain field not loaded");
  a_offset_load: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr_en && waddr == trim_cfg_pkg::ADDR_OFFSET
    |=> ofs_mag_q == $past(wdata[15:8]) && ofs_sign_q == $past(wdata[7]))
    else $error("offset fields not loaded");
  a_coarse_load: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr_en && waddr == trim_cfg_pkg::ADDR_COARSE
    |=> coarse_q == $past(wdata[14:11]) && phase_on_q == $past(wdata[15])
        && slow_clk_q == $past(wdata[10]))
    else $error("coarse fields not loaded");
  a_store_load: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr_en && waddr == trim_cfg_pkg::ADDR_STORE
    |=> depth_q == $past(wdata[15:14]) && halt_q == $past(wdata[13])
        && pattern_q == $past(wdata[11]))
    else $error("store fields not loaded");
  a_bad_header: assert property (@(posedge clk_i) disable iff (!resetn_i)
    frame_end && !hdr_ok
    |=> $stable(gain_q) && $stable(depth_q) && $stable(ofs_mag_q))
    else $error("bad header changed a register");
  a_normal_mode: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !mode_q |=> gain_trim_o == trim_cfg_pkg::GAIN_RST && !pattern_output_on_o)
    else $error("setting applied in normal mode");
  a_ext_apply: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_ext_held |-> gain_trim_o == $past(gain_q) && fine_delay_o == $past(fine_q))
    else $error("gain not applied promptly");
  a_done_pulse: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr_en |=> s_done_once)
    else $error("write strobe wrong");

endmodule : trim_cfg_regs

// ==== dv/serial_host.sv ====
// host model that loads frames over the three-wire serial port
`timescale 1ns/100ps
module serial_host (
  // serial pins toward the device
  output logic sclk_o,
  output logic serial_in_line_o,
  output logic sel_n_o
);
  ////////////////////////////////////////////////////////////////////////////
  // idle: clock parked low, select high
  initial
  begin
    sclk_o  = 1'b0;
    serial_in_line_o = 1'b1;
    sel_n_o = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////
  // shift nbits of w msb first, data moves only while the clock is low
  task automatic send(input logic [31:0] w, input int nbits, input bit hold);
    int i;
    sel_n_o = 1'b0;
    for (i = 31; i > 31 - nbits; i--)
    begin
      serial_in_line_o = w[i];
      #24 sclk_o = 1'b1;
      #24 sclk_o = 1'b0;
    end
    // released line is undriven, so show the inverse of the last bit
    serial_in_line_o = ~serial_in_line_o;
    if (!hold)
      sel_n_o = 1'b1;
  endtask : send
endmodule : serial_host

// ==== dv/trim_cfg_regs_tb.sv ====
// self-checking bench for the serial trim and capture configuration registers
`timescale 1ns/100ps
module trim_cfg_regs_tb;
  logic        clk_i;      // system clock
  logic        resetn_i;   // async reset, active low
  logic        ext_mode_i; // extended control mode
  logic        sclk;       // serial clock from host
  logic        serial_in_line; // serial data from host
  logic        sel_n;      // serial select from host
  wire  [36:0] got;        // all settings, packed; a net, as many ports drive slices
  wire         done;       // write strobe
  logic [36:0] exp_v;      // expected settings
  int          n_errors;   // mismatches
  int          compares;   // comparisons made
  int          n_done;     // strobes seen
  int          n_want;     // strobes expected
  int          cycles;     // timeout counter
  // reset settings, packed like got
  localparam logic [36:0] RST_V = {8'h00, 1'b0, 9'h100, 9'h000, 1'b0, 4'h0, 1'b0,
                                   2'h2, 1'b1, 1'b0};
  ////////////////////////////////////////////////////////////////////////////
  serial_host serial_host_inst (
    .sclk_o(sclk), .serial_in_line_o(serial_in_line), .sel_n_o(sel_n));
  trim_cfg_regs trim_cfg_regs_inst (
    .clk_i(clk_i), .resetn_i(resetn_i), .serial_clk_i(sclk),
    .serial_in_line_i(serial_in_line), .serial_select_n_i(sel_n),
    .ext_mode_i(ext_mode_i),
    .offset_mag_o(got[36:29]), .offset_neg_o(got[28]), .gain_trim_o(got[27:19]),
    .fine_delay_o(got[18:10]), .phase_shift_on_o(got[9]),
    .coarse_delay_field_o(got[8:5]), .slow_sample_clock_bit_o(got[4]),
    .store_depth_select_o(got[3:2]), .halt_when_full_o(got[1]),
    .pattern_output_on_o(got[0]), .write_done_o(done));
  ////////////////////////////////////////////////////////////////////////////
  // 200 MHz clock
  always #2.5 clk_i = ~clk_i;
  // count strobes; cut a hang short after a generous ceiling
  // sampled on the falling edge, where the strobe has settled
  always @(negedge clk_i)
  begin
    if (done === 1'b1)
      n_done++;
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic cmp_v(input logic [36:0] g, input logic [36:0] e);
    compares++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected settings at %0t: got %h want %h", $time, g, e);
    end
  endtask : cmp_v
  task automatic cmp_n(input int g, input int e);
    compares++;
    if (g != e)
    begin
      n_errors++;
      $display("unexpected strobe count at %0t: got %0d want %0d", $time, g, e);
    end
  endtask : cmp_n
  // good-header frame; the model tracks which fields the address owns
  task automatic wr(input logic [3:0] a, input logic [15:0] d, input bit hold);
    @(negedge clk_i);
    serial_host_inst.send({12'h001, a, d}, 32, hold);
    n_want++;
    case (a)
      4'h2: exp_v[36:28] = d[15:7];
      4'h3: exp_v[27:19] = d[15:7];
      4'hd: exp_v[18:10] = d[15:7];
      4'he: exp_v[9:4] = d[15:10];
      4'hf: exp_v[3:0] = {d[15:13], d[11]};
      default: ; // reserved and 1h store nothing here
    endcase
  endtask : wr
  // settle past synchronisers, then compare settings and strobes
  task automatic chk(input logic [36:0] e);
    repeat (10) @(negedge clk_i);
    cmp_v(got, e);
    cmp_n(n_done, n_want);
  endtask : chk
  task automatic conclude();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_i = 1'b0;
    resetn_i = 1'b0;
    ext_mode_i = 1'b1;
    repeat (10) @(negedge clk_i);
    cmp_v(got, RST_V);
    resetn_i = 1'b1;
    exp_v = RST_V;
    repeat (4) @(negedge clk_i);
    wr(4'h2, 16'ha5ff, 0);
    chk(exp_v);
    wr(4'h3, 16'h607f, 1);
    wr(4'h3, 16'he07f, 0);
    chk(exp_v);
    wr(4'hd, 16'hffff, 0);
    chk(exp_v);
    wr(4'h1, 16'hbeff, 1);
    wr(4'he, 16'hcfff, 0);
    chk(exp_v);
    wr(4'hf, 16'h4fff, 0);
    chk(exp_v);
    wr(4'h5, 16'h0000, 0);
    chk(exp_v);
    serial_host_inst.send({12'h003, 4'h2, 16'h00ff}, 32, 0);
    chk(exp_v);
    serial_host_inst.send({12'h001, 4'h3, 16'h007f}, 20, 0);
    chk(exp_v);
    ext_mode_i = 1'b0;
    wr(4'h2, 16'h01ff, 0);
    chk(RST_V);
    ext_mode_i = 1'b1;
    chk(exp_v);
    resetn_i = 1'b0;
    repeat (3) @(negedge clk_i);
    cmp_v(got, RST_V);
    // release again: the stored copies must be back at reset values as well
    resetn_i = 1'b1;
    exp_v = RST_V;
    chk(exp_v);
    wr(4'h3, 16'hc07f, 0);
    chk(exp_v);
    conclude();
  end
endmodule : trim_cfg_regs_tb
